// ### pkg/sbsc_pkg.sv
// Operation
// - strobe with chip disabled gives deselect cycle
// - enabled processor strobe starts burst read
// - controller strobe starts burst, direction from qualifier
// - no strobe, step low: advance, then access
// - no strobe, step high: repeat current address
// - first low enable high masks processor strobe
// - write when all-lanes or lane gate low
// - output enable high kills drivers asynchronously
// - drivers turn on only in read-data cycles
// - dummy read advances counter like normal read
// - every decode table combination is supported
// - linear or interleaved order, wraps after four
// - lane gate low writes selected lanes only
// - all-lanes write low writes every lane
// - data lines undriven after a write edge in flow-through, one edge later in pipeline
`default_nettype none

package sbsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // array geometry
  localparam int SBSC_ADDR_W = 4;
  localparam int SBSC_DEPTH = 16;
  localparam int SBSC_LANES = 4;
  localparam int SBSC_LANE_W = 8;
  localparam int SBSC_DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the wishbone port
  localparam int SBSC_WB_ADR_W = 8;
  localparam logic [7:0] SBSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] SBSC_OFS_STATUS = 8'h04;

  // control register fields and reset value
  localparam int SBSC_CTRL_ORDER_BIT = 0;
  localparam int SBSC_CTRL_FT_BIT = 1;
  localparam logic [1:0] SBSC_CTRL_RESET = 2'h3;

  // status register fields
  localparam int SBSC_STAT_ADDR_LSB = 0;
  localparam int SBSC_STAT_KIND_LSB = 4;
  localparam int SBSC_STAT_VALID_BIT = 7;
  localparam int SBSC_STAT_CNT_LSB = 8;

  // values after reset
  localparam logic [1:0] SBSC_CNT_RESET = 2'h0;
  localparam logic [3:0] SBSC_ADDR_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // kind of cycle decoded at a clock edge
  typedef enum logic [2:0] {
    SBSC_DESELECT,
    SBSC_BEGIN_READ,
    SBSC_BEGIN_WRITE,
    SBSC_CONT_READ,
    SBSC_CONT_WRITE,
    SBSC_SUSP_READ,
    SBSC_SUSP_WRITE
  } sbsc_cycle_t;

endpackage

`default_nettype wire

// ### hw/sbsc_core.sv
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`default_nettype none

module sbsc_core
  import sbsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [SBSC_WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // synchronous memory pins
  input wire logic [SBSC_ADDR_W-1:0] addr_i,
  input wire logic chip_sel_low_a_n_i,
  input wire logic chip_sel_high_i,
  input wire logic chip_sel_low_b_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  input wire logic all_lanes_write_n_i,
  input wire logic lane_write_gate_n_i,
  input wire logic lane0_write_n_i,
  input wire logic lane1_write_n_i,
  input wire logic lane2_write_n_i,
  input wire logic lane3_write_n_i,
  input wire logic output_enable_n_i,
  input wire logic [SBSC_DATA_W-1:0] dq_i,
  output logic [SBSC_DATA_W-1:0] dq_o,
  output logic dq_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [1:0] ctrl_ff;
  logic [1:0] cnt_ff;
  logic [SBSC_ADDR_W-1:0] base_ff;
  logic [SBSC_ADDR_W-1:0] last_addr_ff;
  sbsc_cycle_t kind_ff;
  logic [SBSC_DATA_W-1:0] mem_ff [SBSC_DEPTH];
  logic [SBSC_DATA_W-1:0] s1_data_ff;
  logic s1_valid_ff;
  logic [SBSC_DATA_W-1:0] out_data_ff;
  logic out_valid_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // mode bits held in the control register

  wire linear_order_sel_n = ctrl_ff[SBSC_CTRL_ORDER_BIT];
  wire flow_through_sel_n = ctrl_ff[SBSC_CTRL_FT_BIT];
  wire [SBSC_LANES-1:0] lane_write_n = {lane3_write_n_i, lane2_write_n_i,
                                        lane1_write_n_i, lane0_write_n_i};

  ////////////////////////////////////////////////////////////////////////////
  // cycle decode at the rising edge

  // combined enable: high enable high, both low enables low
  wire chip_on = chip_sel_high_i & ~chip_sel_low_a_n_i & ~chip_sel_low_b_n_i;
  // processor strobe only counts while the first low enable is low
  wire psp_go = ~processor_addr_strobe_n_i & ~chip_sel_low_a_n_i;
  wire csp_go = ~controller_addr_strobe_n_i;
  wire strobe_go = psp_go | csp_go;
  // a starting strobe with the chip off is a deselect
  wire is_desel = strobe_go & ~chip_on;
  wire is_begin = strobe_go & chip_on;
  // write qualifier from global write and lane gate
  wire wr_q = ~all_lanes_write_n_i | ~lane_write_gate_n_i;
  // processor strobe forces a read; controller strobe follows qualifier
  wire begin_wr = ~psp_go & wr_q;
  wire is_step = ~strobe_go & ~burst_step_n_i;
  wire is_susp = ~strobe_go & burst_step_n_i;
  // every combination lands in exactly one kind of cycle
  wire is_write = is_begin ? begin_wr : (~is_desel & wr_q);
  wire is_read = ~is_desel & ~is_write;

  ////////////////////////////////////////////////////////////////////////////
  // burst counter and beat address

  // restart at zero on a new burst, count on a step, else hold
  wire [1:0] nxt_cnt = is_begin ? SBSC_CNT_RESET :
                       is_step ? cnt_ff + 2'h1 : cnt_ff;
  // linear adds, interleaved xors; two bits wrap after four beats
  wire [1:0] lin_lo = base_ff[1:0] + nxt_cnt;
  wire [1:0] ilv_lo = base_ff[1:0] ^ nxt_cnt;
  wire [1:0] burst_lo = linear_order_sel_n ? ilv_lo : lin_lo;
  wire [SBSC_ADDR_W-1:0] burst_addr = {base_ff[SBSC_ADDR_W-1:2], burst_lo};
  // new bursts take the external address
  wire [SBSC_ADDR_W-1:0] beat_addr = is_begin ? addr_i : burst_addr;
  wire [SBSC_ADDR_W-1:0] nxt_base = is_begin ? addr_i : base_ff;

  // decoded kind for the status register
  wire sbsc_cycle_t nxt_kind = is_desel ? SBSC_DESELECT :
                               is_begin ? (begin_wr ? SBSC_BEGIN_WRITE : SBSC_BEGIN_READ) :
                               is_step ? (wr_q ? SBSC_CONT_WRITE : SBSC_CONT_READ) :
                               (wr_q ? SBSC_SUSP_WRITE : SBSC_SUSP_READ);

  // burst position only moves on real cycles; deselect uses no address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= SBSC_CNT_RESET;
      base_ff <= SBSC_ADDR_RESET;
      last_addr_ff <= SBSC_ADDR_RESET;
      kind_ff <= SBSC_DESELECT;
    end else begin
      kind_ff <= nxt_kind;
      if (!is_desel) begin
        cnt_ff <= nxt_cnt;
        base_ff <= nxt_base;
        last_addr_ff <= beat_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte lane write merge

  wire [SBSC_DATA_W-1:0] mem_rd = mem_ff[beat_addr];
  logic [SBSC_LANES-1:0] lane_we;
  logic [SBSC_DATA_W-1:0] wr_word;

  // per lane: global write takes all lanes, else the gated lane enables
  genvar gi;
  generate
    for (gi = 0; gi < SBSC_LANES; gi++) begin : g_lane
      assign lane_we[gi] = is_write &
                           (~all_lanes_write_n_i | ~lane_write_n[gi]);
      assign wr_word[gi*SBSC_LANE_W +: SBSC_LANE_W] = lane_we[gi] ?
          dq_i[gi*SBSC_LANE_W +: SBSC_LANE_W] :
          mem_rd[gi*SBSC_LANE_W +: SBSC_LANE_W];
    end
  endgenerate

  // write data is taken at the same edge as the beat address
  always_ff @(posedge clk_i) begin
    if (is_write) begin
      mem_ff[beat_addr] <= wr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data path

  // flow-through loads the output straight from the array,
  // pipeline goes through one more stage
  wire ft_mode = ~flow_through_sel_n;
  wire [SBSC_DATA_W-1:0] nxt_out_data = ft_mode ? mem_rd : s1_data_ff;
  wire nxt_out_valid = ft_mode ? is_read : s1_valid_ff;

  // valid is cleared by writes and deselects, so the lanes stay off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_valid_ff <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      s1_valid_ff <= is_read;
      out_valid_ff <= nxt_out_valid;
    end
  end

  // read words, all lanes together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_data_ff <= '0;
      out_data_ff <= '0;
    end else begin
      s1_data_ff <= mem_rd;
      out_data_ff <= nxt_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pin drive

  assign dq_o = out_data_ff;
  // output enable gates without the clock, so a high level
  // turns the drivers off at once; a dummy read never drives
  assign dq_oe_o = out_valid_ff & ~output_enable_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  // one access per strobe, answered one cycle later
  wire wb_hit = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire hit_ctrl = (wb_adr_i == SBSC_OFS_CTRL);
  wire hit_status = (wb_adr_i == SBSC_OFS_STATUS);
  wire ctrl_wr = wb_hit & wb_we_i & wb_sel_i[0] & hit_ctrl;

  // status word: beat address, cycle kind, output valid, counter
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[SBSC_STAT_ADDR_LSB +: SBSC_ADDR_W] = last_addr_ff;
    status_word[SBSC_STAT_KIND_LSB +: 3] = kind_ff;
    status_word[SBSC_STAT_VALID_BIT] = out_valid_ff;
    status_word[SBSC_STAT_CNT_LSB +: 2] = cnt_ff;
  end

  // read mux by address; unmapped reads as zero
  wire [31:0] nxt_rdat = hit_ctrl ? {30'h0, ctrl_ff} :
                         hit_status ? status_word : 32'h0;

  // control register, byte lane zero only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= SBSC_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= wb_dat_i[1:0];
    end
  end

  // acknowledge and registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff <= wb_hit;
      if (wb_hit) begin
        rdat_ff <= nxt_rdat;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule

`default_nettype wire

// ### verif/sbsc_sva.sv
`default_nettype none
module sbsc_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic chip_sel_low_a_n_i,
  input wire logic chip_sel_high_i,
  input wire logic chip_sel_low_b_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic all_lanes_write_n_i,
  input wire logic lane_write_gate_n_i,
  input wire logic output_enable_n_i,
  input wire logic dq_oe_o
);
  // cycle decode seen from the pins
  wire logic chip_on = chip_sel_high_i & ~chip_sel_low_a_n_i & ~chip_sel_low_b_n_i;
  wire logic psp = ~processor_addr_strobe_n_i & ~chip_sel_low_a_n_i;
  wire logic strobe = psp | ~controller_addr_strobe_n_i;
  wire logic wr = ~all_lanes_write_n_i | ~lane_write_gate_n_i;
  wire logic rd = strobe ? chip_on & (psp | ~wr) : ~wr;
  wire logic dsel = strobe & ~chip_on;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence two_rd; rd ##1 rd; endsequence
  sequence two_quiet; !rd ##1 !rd; endsequence
  ////////////////////////////////////////////////////////////////////////////
  oe_kill_a: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("drive with output enable off");
  idle_quiet_a: assert property (two_quiet |=> !dq_oe_o)
    else $error("drive after non-read cycles");
  read_drive_a: assert property (two_rd |=> output_enable_n_i || dq_oe_o)
    else $error("read data not driven");
  desel_quiet_a: assert property (dsel ##1 dsel |=> !dq_oe_o)
    else $error("drive after deselect");
  drive_cause_a: assert property (dq_oe_o |-> $past(rd) || $past(rd, 2))
    else $error("drive without a read");
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
endmodule
bind sbsc_core sbsc_sva sbsc_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .chip_sel_low_a_n_i, .chip_sel_high_i, .chip_sel_low_b_n_i, .processor_addr_strobe_n_i,
  .controller_addr_strobe_n_i, .all_lanes_write_n_i, .lane_write_gate_n_i,
  .output_enable_n_i, .dq_oe_o);
`default_nettype wire

// ### verif/sbsc_ctl.sv
`default_nettype none
module sbsc_ctl (
  input wire logic clk_i,
  output logic [12:0] ctl_o,
  output logic [3:0] adr_o,
  output logic [31:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // controls, low bit first: low_a, high, low_b, psp, csp, step, gw, bw, lanes, oe
  initial begin
    ctl_o = 13'h1fed;
    adr_o = 4'h0;
    dq_o = 32'h0;
  end
  // one pin cycle per edge; released data lines toggle
  task op(input logic [12:0] c, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    ctl_o <= c;
    adr_o <= a;
    dq_o <= (!c[6] || !c[7]) ? d : ~dq_o;
  endtask
  // output enable moves at any moment
  task oe_now(input logic v);
    ctl_o[12] <= v;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_sbsc_core.sv
`default_nettype none
module tb_sbsc_core import sbsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] EN = 13'h1ffa, IDLE = 13'h1fed, PSP = 13'h8, CSP = 13'h10;
  localparam logic [12:0] STEP = 13'h20, GW = 13'h40, BW = 13'h80, OE = 13'h1000;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, dq_o, q, mem [16];
  logic wb_ack_o, dq_oe_o;
  wire logic [12:0] c;
  wire logic [3:0] addr_i;
  wire logic [31:0] dq_i;
  int fails = 0, cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  sbsc_ctl sbsc_ctl_i (.clk_i, .ctl_o(c), .adr_o(addr_i), .dq_o(dq_i));
  sbsc_core sbsc_core_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .addr_i, .chip_sel_low_a_n_i(c[0]), .chip_sel_high_i(c[1]),
    .chip_sel_low_b_n_i(c[2]), .processor_addr_strobe_n_i(c[3]),
    .controller_addr_strobe_n_i(c[4]), .burst_step_n_i(c[5]), .all_lanes_write_n_i(c[6]),
    .lane_write_gate_n_i(c[7]), .lane0_write_n_i(c[8]), .lane1_write_n_i(c[9]),
    .lane2_write_n_i(c[10]), .lane3_write_n_i(c[11]), .output_enable_n_i(c[12]), .dq_i,
    .dq_o, .dq_oe_o);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string s, input logic [31:0] v, input logic [31:0] e);
    cmp_count++;
    if (v !== e) begin
      fails++;
      $display("wrong value %s exp %h seen %h", s, e, v);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // classic single cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function logic [3:0] nx(input logic [3:0] a, input int n, input logic il);
    return {a[3:2], il ? a[1:0] ^ 2'(n) : a[1:0] + 2'(n)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    wb(1'b0, SBSC_OFS_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h3);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  // single-word writes through the controller strobe
  task t_fill;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'ha5c30000 | 32'(i * 32'h0101);
      sbsc_ctl_i.op(EN & ~CSP & ~GW & ~OE, 4'(i), mem[i]);
      #1 chk("wr drive", 32'(dq_oe_o), 32'h0);
    end
  endtask
  // five-beat burst from 5 in each order and output mode
  task t_burst(input logic [1:0] m);
    int k;
    wb(1'b1, SBSC_OFS_CTRL, {30'h0, m});
    wb(1'b0, SBSC_OFS_CTRL, 32'h0);
    chk("ctrl", q, {30'h0, m});
    for (int n = 0; n < 7; n++) begin
      sbsc_ctl_i.op(n == 0 ? EN & ~PSP & ~GW & ~OE : n < 5 ? EN & ~STEP & ~OE : IDLE & ~OE,
        4'h5, 32'h0);
      #1 k = n - (m[1] ? 2 : 1);
      if (k >= 0 && k < 5) chk("burst", dq_o, mem[nx(4'h5, k, m[0])]);
      if (k >= 0 && k < 5) chk("rd drive", 32'(dq_oe_o), 32'h1);
    end
  endtask
  // lane writes, then read back in flow-through
  task t_lanes;
    wb(1'b1, SBSC_OFS_CTRL, 32'h0);
    sbsc_ctl_i.op(EN & ~CSP & ~BW & ~OE & ~13'h500, 4'h3, 32'h11223344);
    mem[3] = {mem[3][31:24], 8'h22, mem[3][15:8], 8'h44};
    sbsc_ctl_i.op(EN & ~CSP & ~BW & ~OE, 4'h3, 32'h0);
    #1 chk("lane drive", 32'(dq_oe_o), 32'h0);
    sbsc_ctl_i.op(EN & ~CSP & ~OE, 4'h3, 32'h0);
    sbsc_ctl_i.op(IDLE & ~OE, 4'h0, 32'h0);
    #1 chk("lanes", dq_o, mem[3]);
  endtask
  // dummy reads, suspend, masked strobe and async disable
  task t_dummy;
    sbsc_ctl_i.op(EN & ~CSP, 4'h8, 32'h0);
    sbsc_ctl_i.op(EN & ~STEP, 4'h0, 32'h0);
    #1 chk("dummy", 32'(dq_oe_o), 32'h0);
    sbsc_ctl_i.op(EN & ~OE, 4'h0, 32'h0);
    #1 chk("dummy step", dq_o, mem[9]);
    sbsc_ctl_i.op((EN | 13'h1) & ~PSP & ~STEP & ~OE, 4'h0, 32'h0);
    #1 chk("suspend", dq_o, mem[9]);
    sbsc_ctl_i.op(IDLE & ~OE, 4'h0, 32'h0);
    #1 chk("masked", dq_o, mem[10]);
    #1 sbsc_ctl_i.oe_now(1'b1);
    #1 chk("oe off", 32'(dq_oe_o), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_fill;
    for (int i = 0; i < 4; i++) t_burst(2'(i));
    t_lanes;
    t_dummy;
    stop_test;
  end
  // watchdog
  initial begin
    #20000;
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
